// ==== src/tcu_defines.vh ====
`ifndef TCU_DEFINES_VH
`define TCU_DEFINES_VH
// Cycle states
`define TCU_ST_IDLE 3'h0
`define TCU_ST_T1 3'h1
`define TCU_ST_T2 3'h2
`define TCU_ST_T3 3'h3
`define TCU_ST_TW 3'h4
`define TCU_ST_T4 3'h5
// Widths and counts
`define TCU_WAIT_W 4
`define TCU_SLOW_EXTRA 2'h2
`define TCU_SYNC_STAGES 2
`endif

// ==== src/tcu_wait_gen.v ====
`timescale 1ns/100ps
`include "tcu_defines.vh"
module tcu_wait_gen #(
  parameter WAIT_W = `TCU_WAIT_W
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  input wire tick_i,
  // Control
  input wire start_i,
  input wire [WAIT_W-1:0] fixed_count_i,
  input wire cont_stall_n_i,
  // Status
  output wire wait_o,
  output reg ready_o
);
  reg [WAIT_W-1:0] count;
  reg running;
  reg pending;

  // Counter; continuous stall at start defers the fixed count, stall during the count cancels it
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= {WAIT_W{1'b0}};
      running <= 1'b0;
      pending <= 1'b0;
    end else if (start_i) begin // [RQ10]
      if (!cont_stall_n_i) begin
        pending <= 1'b1; // [RQ8]
        count <= fixed_count_i;
        running <= 1'b0;
      end else begin
        count <= fixed_count_i; // [RQ6]
        running <= (fixed_count_i != {WAIT_W{1'b0}});
      end
    end else if (tick_i) begin
      if (!cont_stall_n_i) begin
        running <= 1'b0; // [RQ9]
        if (running) pending <= 1'b0;
      end else if (pending) begin
        pending <= 1'b0; // [RQ8]
        running <= (count != {WAIT_W{1'b0}});
      end else if (running) begin
        count <= count - {{(WAIT_W-1){1'b0}}, 1'b1};
        if (count == {{(WAIT_W-1){1'b0}}, 1'b1}) running <= 1'b0;
      end
    end
  end

  // Wait held while counting or continuous stall low
  assign wait_o = running | pending | ~cont_stall_n_i; // [RQ11] [RQ7]

  // Ready drops on start, recovers when wait clears
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ready_o <= 1'b1;
    end else if (start_i) begin
      ready_o <= 1'b0; // [RQ12]
    end else if (!wait_o) begin
      ready_o <= 1'b1; // [RQ12]
    end
  end
endmodule // tcu_wait_gen

// ==== src/tcu_timing_ctrl.v ====
`timescale 1ns/100ps
`include "tcu_defines.vh"
// What this block does
// [RQ1] Input clock divided by two for the tick, by four for phases
// [RQ2] Fast clock output at full input rate
// [RQ3] Two non-overlapping phases, TTL clock, tick
// [RQ4] Reset input synchronised to reset output
// [RQ5] Ready and reset synchronised for processor
// [RQ6] Fixed stall inputs insert 0 to 15 waits
// [RQ7] Continuous stall low waits without limit
// [RQ8] Fixed count applies after continuous released
// [RQ9] Stall during count forces continuous wait
// [RQ10] Counter starts only on sequencer start pulse
// [RQ11] Wait held while counting or stall low
// [RQ12] Ready low on start, high after wait
// [RQ13] Address strobe restarts T-state tracking
// [RQ14] Latch direction and slow select at start
// [RQ15] Sequencer stretches cycle while wait asserted
// [RQ16] Marker pulses at second and last T-state
// [RQ17] Generate read, write, buffer enable strobes
// [RQ18] Slow cycles stretch strobes beyond waits
// [RQ19] Continuous stall holds cycle for arbitration
// [RQ20] Four T-states, waits between T3 and T4
module tcu_timing_ctrl #(
  parameter WAIT_W = `TCU_WAIT_W
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // Oscillator side
  output wire fast_ttl_clock_o,
  output reg phase1_o,
  output reg phase2_o,
  output reg ttl_phase_clock_o,
  // Reset pins
  input wire raw_reset_in_n_i,
  output reg sync_reset_out_n_o,
  // Stall inputs
  input wire [WAIT_W-1:0] fixed_stall_n_i,
  input wire continuous_stall_n_i,
  input wire ext_ready_i,
  output reg cpu_ready_o,
  // Bus cycle
  input wire addr_strobe_n_i,
  input wire xfer_direction_n_i,
  input wire slow_periph_n_i,
  output reg tstate_marker_n_o,
  output reg read_strobe_n_o,
  output reg write_strobe_n_o,
  output reg buf_enable_n_o
);
  // Divide-by-two: ref_clk_i stands for the oscillator input
  reg div2;
  reg [1:0] quarter;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      div2 <= 1'b0;
    end else begin
      div2 <= ~div2; // [RQ1]
    end
  end
  // Fast clock runs at full rate; ref_clk_i goes straight to the port
  assign fast_ttl_clock_o = ref_clk_i; // [RQ2]

  // Phases from a quarter counter; dead slots keep them apart
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      quarter <= 2'h0;
      phase1_o <= 1'b0;
      phase2_o <= 1'b0;
      ttl_phase_clock_o <= 1'b0;
    end else begin
      quarter <= quarter + 2'h1;
      phase1_o <= (quarter == 2'h3); // [RQ3]
      phase2_o <= (quarter == 2'h1); // [RQ3]
      ttl_phase_clock_o <= ~quarter[1]; // [RQ3]
    end
  end
  // Internal tick: one per system clock period
  wire tick = div2;

  // Reset and ready synchronisers, two stages each
  reg rst_meta;
  reg rst_sync;
  reg rdy_meta;
  reg rdy_sync;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      rst_meta <= raw_reset_in_n_i; // [RQ5]
      rst_sync <= rst_meta;
      rdy_meta <= ext_ready_i; // [RQ5]
      rdy_sync <= rdy_meta;
    end
  end
  // Reset output changes only on tick, so it lines up with phases
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_reset_out_n_o <= 1'b0;
    end else if (tick) begin
      sync_reset_out_n_o <= rst_sync; // [RQ4]
    end
  end

  // Wait-state generator
  reg [2:0] state;
  reg [2:0] next_state;
  reg start_pulse;
  reg is_read;
  reg is_slow;
  reg [1:0] slow_cnt;
  wire gen_wait;
  wire gen_ready;
  tcu_wait_gen #(
    .WAIT_W(WAIT_W)
  ) u_wait (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .start_i(start_pulse),
    .fixed_count_i(~fixed_stall_n_i),
    .cont_stall_n_i(continuous_stall_n_i),
    .wait_o(gen_wait),
    .ready_o(gen_ready)
  );

  // Processor ready combines generator and external ready
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      cpu_ready_o <= 1'b1;
    end else begin
      cpu_ready_o <= gen_ready & rdy_sync; // [RQ5]
    end
  end

  // Stay in wait while generator waits or slow stretch remains
  wire hold = gen_wait | (is_slow && slow_cnt != 2'h0);

  // Next-state: four T-states plus waits after T3
  always @* begin
    next_state = state;
    case (state)
      `TCU_ST_IDLE: next_state = `TCU_ST_IDLE;
      `TCU_ST_T1: next_state = `TCU_ST_T2;
      `TCU_ST_T2: next_state = `TCU_ST_T3;
      `TCU_ST_T3: next_state = hold ? `TCU_ST_TW : `TCU_ST_T4; // [RQ20] [RQ15]
      `TCU_ST_TW: next_state = hold ? `TCU_ST_TW : `TCU_ST_T4; // [RQ15] [RQ18] [RQ19]
      `TCU_ST_T4: next_state = `TCU_ST_IDLE;
      default: next_state = `TCU_ST_IDLE;
    endcase
    if (!addr_strobe_n_i) next_state = `TCU_ST_T1; // [RQ13]
  end

  // Sequencer registers, stepped on each system tick
  always @(posedge ref_clk_i) begin
    if (reset_i || !sync_reset_out_n_o) begin
      state <= `TCU_ST_IDLE;
      is_read <= 1'b0;
      is_slow <= 1'b0;
      slow_cnt <= 2'h0;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      if (tick) begin
        state <= next_state;
        if (!addr_strobe_n_i) begin
          is_read <= ~xfer_direction_n_i; // [RQ14]
          is_slow <= ~slow_periph_n_i; // [RQ14]
          slow_cnt <= `TCU_SLOW_EXTRA;
        end
        // Start issued entering T3 so waits are known by T3 exit
        if (state == `TCU_ST_T2 && addr_strobe_n_i) start_pulse <= 1'b1; // [RQ10]
        // Slow stretch counts down from T3 on, after any waits, so it adds exactly its count
        if ((state == `TCU_ST_T3 || state == `TCU_ST_TW) && !gen_wait && slow_cnt != 2'h0) begin
          slow_cnt <= slow_cnt - 2'h1; // [RQ18]
        end
      end
    end
  end

  // Strobe outputs; slow reads open the read strobe one state later, slow writes drop the write strobe in the last wait
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      tstate_marker_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      buf_enable_n_o <= 1'b1;
    end else begin
      tstate_marker_n_o <= ~(state == `TCU_ST_T2 || state == `TCU_ST_T4); // [RQ16]
      buf_enable_n_o <= ~(state == `TCU_ST_T2 || state == `TCU_ST_T3 ||
                          state == `TCU_ST_TW || state == `TCU_ST_T4); // [RQ17]
      read_strobe_n_o <= ~(is_read && ((state == `TCU_ST_T2 && !is_slow) ||
                          state == `TCU_ST_T3 || state == `TCU_ST_TW)); // [RQ17] [RQ20]
      write_strobe_n_o <= ~(!is_read && (state == `TCU_ST_T3 ||
                           (state == `TCU_ST_TW && !(is_slow && slow_cnt == 2'h0)))); // [RQ17] [RQ18]
    end
  end
endmodule // tcu_timing_ctrl

// ==== verification/tcu_checker.sv ====
`timescale 1ns/100ps
// Pin-level watcher for the timing block, one clock domain
module tcu_checker (
  // Clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // Watched pins
  input wire phase1_o,
  input wire phase2_o,
  input wire ttl_phase_clock_o,
  input wire raw_reset_in_n_i,
  input wire sync_reset_out_n_o,
  input wire addr_strobe_n_i,
  input wire cpu_ready_o,
  input wire tstate_marker_n_o,
  input wire read_strobe_n_o,
  input wire write_strobe_n_o,
  input wire buf_enable_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Phase shape and spacing
  AST_PHASE_EXCL: assert property (!(phase1_o && phase2_o)) else $error("phases overlap");
  AST_PHASE_PERIOD: assert property ($rose(phase1_o) |=> !phase1_o [*3] ##1 phase1_o)
    else $error("phase one period wrong");
  AST_TTL_HALF: assert property ($rose(ttl_phase_clock_o) |=> ttl_phase_clock_o ##1 !ttl_phase_clock_o [*2])
    else $error("ttl clock duty wrong");
  // Reset out may only rise after the raw input has been high a while
  AST_RESET_SYNC: assert property ($rose(sync_reset_out_n_o) |-> $past(raw_reset_in_n_i, 2))
    else $error("reset out rose early");
  AST_IDLE_IN_RESET: assert property (!sync_reset_out_n_o [*3] |-> tstate_marker_n_o && buf_enable_n_o)
    else $error("bus active in reset");
  // Strobes and marker
  AST_RW_EXCL: assert property (read_strobe_n_o || write_strobe_n_o) else $error("read and write both low");
  AST_MARK_STATE: assert property ($fell(tstate_marker_n_o) |=> !tstate_marker_n_o ##1 tstate_marker_n_o)
    else $error("marker not one state long");
  AST_STROBE_START: assert property ($fell(addr_strobe_n_i) && sync_reset_out_n_o |-> ##[1:6] !tstate_marker_n_o)
    else $error("no marker after strobe");
  COV_READ: cover property ($fell(read_strobe_n_o));
  COV_WRITE: cover property ($fell(write_strobe_n_o));
  COV_WAIT: cover property ($fell(cpu_ready_o));
endmodule // tcu_checker

bind tcu_timing_ctrl tcu_checker chk (.ref_clk_i, .reset_i, .phase1_o, .phase2_o, .ttl_phase_clock_o,
  .raw_reset_in_n_i, .sync_reset_out_n_o, .addr_strobe_n_i, .cpu_ready_o, .tstate_marker_n_o,
  .read_strobe_n_o, .write_strobe_n_o, .buf_enable_n_o);

// ==== verification/tcu_cpu_model.sv ====
`timescale 1ns/100ps
// Bus master stand-in: one cycle per go pulse, times marker to marker
module tcu_cpu_model (
  // Clock
  input wire ref_clk_i,
  // Bench control
  input wire go_i,
  input wire rd_i,
  input wire slow_i,
  // Device pins
  input wire tstate_marker_n_i,
  output reg addr_strobe_n_o = 1'b1,
  output reg dir_n_o = 1'b1,
  output reg slow_n_o = 1'b1,
  // Result
  output reg [7:0] span_o = 8'h00,
  output reg done_o = 1'b0
);
  reg [7:0] cnt = 8'h00;
  reg [7:0] base = 8'h00;
  reg mk_q = 1'b1;
  // Strobe stays low two edges, so one internal tick always sees it
  always @(posedge ref_clk_i) begin
    mk_q <= tstate_marker_n_i;
    cnt <= cnt + 8'h01;
    done_o <= 1'b0;
    if (cnt == 8'h01)
      addr_strobe_n_o <= 1'b1;
    if (go_i) begin
      cnt <= 8'h00;
      base <= 8'hFF;
      addr_strobe_n_o <= 1'b0;
      dir_n_o <= ~rd_i;
      slow_n_o <= ~slow_i;
    end
    if (mk_q && !tstate_marker_n_i) begin
      if (base == 8'hFF)
        base <= cnt;
      else begin
        span_o <= cnt - base;
        done_o <= 1'b1;
        dir_n_o <= ~dir_n_o; // Released lines show the inverse
        slow_n_o <= ~slow_n_o;
      end
    end
  end
endmodule // tcu_cpu_model

// ==== verification/tcu_timing_ctrl_bench.sv ====
`timescale 1ns/100ps
module tcu_timing_ctrl_bench;
  reg ref_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg raw_n = 1'b0;
  reg [3:0] fix_n = 4'hF;
  reg cont_n = 1'b1;
  reg go = 1'b0;
  reg rd = 1'b1;
  reg slow = 1'b0;
  reg ext_rdy = 1'b1;
  reg saw_rd, saw_wr, saw_rdy, saw_be;
  reg [7:0] sp;
  reg [7:0] c1, c2, ct;
  integer mismatches = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer k;
  wire fast_ttl_clock, ph1, ph2, ttl, srst_n, rdy, mk_n, rd_n, wr_n, be_n, as_n, dir_n, per_n, done;
  wire [7:0] span;
  always #2 ref_clk_i = ~ref_clk_i;
  tcu_timing_ctrl dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .fast_ttl_clock_o(fast_ttl_clock), .phase1_o(ph1),
    .phase2_o(ph2), .ttl_phase_clock_o(ttl), .raw_reset_in_n_i(raw_n), .sync_reset_out_n_o(srst_n),
    .fixed_stall_n_i(fix_n), .continuous_stall_n_i(cont_n), .ext_ready_i(ext_rdy), .cpu_ready_o(rdy),
    .addr_strobe_n_i(as_n), .xfer_direction_n_i(dir_n), .slow_periph_n_i(per_n), .tstate_marker_n_o(mk_n),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .buf_enable_n_o(be_n));
  tcu_cpu_model cpu (.ref_clk_i(ref_clk_i), .go_i(go), .rd_i(rd), .slow_i(slow), .tstate_marker_n_i(mk_n),
    .addr_strobe_n_o(as_n), .dir_n_o(dir_n), .slow_n_o(per_n), .span_o(span), .done_o(done));
  // Strobe watchers and hang guard
  always @(posedge ref_clk_i) begin
    if (!rd_n) saw_rd = 1'b1;
    if (!wr_n) saw_wr = 1'b1;
    if (!rdy) saw_rdy = 1'b1;
    if (!be_n) saw_be = 1'b1;
    cycles = cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  task check(input [47:0] name, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s expected %0h seen %0h", name, exp, seen);
      end
    end
  endtask
  // One bus cycle through the model; span is marker to marker
  task run(input r, input s);
    integer n;
    begin
      saw_rd = 1'b0;
      saw_wr = 1'b0;
      saw_rdy = 1'b0;
      saw_be = 1'b0;
      rd <= r;
      slow <= s;
      go <= 1'b1;
      @(posedge ref_clk_i);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 300) begin
        @(posedge ref_clk_i);
        n = n + 1;
      end
      check("done", n < 300, 1'b1);
      sp = span;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask
  task test_reset;
    begin
      repeat (6) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      raw_n <= 1'b1;
      repeat (12) @(posedge ref_clk_i);
      check("srst", srst_n, 1'b1);
      #1 check("fast_ttl_clock", fast_ttl_clock, 1'b1);
      #2 check("fast_ttl_clock", fast_ttl_clock, 1'b0);
      c1 = 8'h00;
      c2 = 8'h00;
      ct = 8'h00;
      // Two full phase periods: each phase high once per four edges
      repeat (8) begin
        @(posedge ref_clk_i);
        c1 = c1 + ph1;
        c2 = c2 + ph2;
        ct = ct + ttl;
      end
      check("ph1", c1, 8'h02);
      check("ph2", c2, 8'h02);
      check("ttl", ct, 8'h04);
      $display("test reset done");
    end
  endtask
  task test_fast;
    begin
      run(1'b1, 1'b0);
      check("span", sp, 8'h04);
      check("rd", saw_rd, 1'b1);
      check("wr", saw_wr, 1'b0);
      check("be", saw_be, 1'b1);
      check("rdylow", saw_rdy, 1'b1);
      check("rdy", rdy, 1'b1);
      // External ready passes two sync stages and the output flop
      ext_rdy <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      check("extrdy", rdy, 1'b0);
      ext_rdy <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      check("extrdy", rdy, 1'b1);
      run(1'b0, 1'b0);
      check("wr", saw_wr, 1'b1);
      check("rd", saw_rd, 1'b0);
      $display("test fast done");
    end
  endtask
  // Counts 1, 3, 7 and 15, the last the largest the inputs allow
  task test_fixed;
    begin
      for (k = 1; k < 16; k = k * 2 + 1) begin
        fix_n <= ~k[3:0];
        @(posedge ref_clk_i);
        run(1'b1, 1'b0);
        check("fixlo", sp >= 2 * (2 + k), 1'b1);
        check("fixhi", sp <= 2 * (2 + k), 1'b1);
      end
      fix_n <= 4'hF;
      $display("test fixed done");
    end
  endtask
  task test_slow;
    begin
      run(1'b1, 1'b1);
      check("slow", sp, 8'h08);
      check("rd", saw_rd, 1'b1);
      $display("test slow done");
    end
  endtask
  // Continuous stall first, count of three deferred behind it
  task test_cont;
    begin
      fix_n <= 4'hC;
      fork
        run(1'b0, 1'b0);
        begin
          cont_n <= 1'b0;
          repeat (30) @(posedge ref_clk_i);
          cont_n <= 1'b1;
        end
      join
      check("cont", sp >= 8'h20, 1'b1);
      check("wr", saw_wr, 1'b1);
      fix_n <= 4'hF;
      $display("test cont done");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    test_reset;
    test_fast;
    test_fixed;
    test_slow;
    test_cont;
    stop_test;
  end
endmodule // tcu_timing_ctrl_bench
